// ==== src/rx_cfg_pkg.sv ====
// Package for the receiver sync and correlation configuration bank.
// Assumes one 20 MHz clock and an 8-bit register port.
package rx_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  localparam logic [7:0] OFS_PAT_HI = 8'h5A;
  localparam logic [7:0] OFS_PAT_LO = 8'h5B;
  localparam logic [7:0] OFS_SOF_MODE = 8'h5C;
  localparam logic [7:0] OFS_DEMOD = 8'h5D;
  localparam logic [7:0] OFS_CORR = 8'h5E;
  localparam logic [7:0] OFS_TRIM = 8'h5F;

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] MSK_DEMOD = 8'h3F;
  localparam logic [7:0] MSK_CORR = 8'hF8;

  // Reset values
  localparam logic [7:0] RST_PAT = 8'h00;
  localparam logic [7:0] RST_SOF_MODE = 8'h00;
  localparam logic [7:0] RST_DEMOD = 8'h00;
  localparam logic [7:0] RST_CORR = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_LEN = 4;
  localparam int unsigned POS_NEG = 3;
  localparam int unsigned POS_HALF = 2;
  localparam int unsigned POS_TYPE = 0;
  localparam int unsigned POS_AVG = 5;
  localparam int unsigned POS_SHAPE = 4;
  localparam int unsigned POS_PEAK = 3;
  localparam int unsigned POS_INV = 2;
  localparam int unsigned POS_FSK = 1;
  localparam int unsigned POS_BPSK = 0;
  localparam int unsigned POS_FREQ = 6;
  localparam int unsigned POS_RATE = 4;
  localparam int unsigned POS_SHORT = 3;

  // Correlation window lengths in values
  localparam logic [6:0] WIN_SHORT = 7'h20;
  localparam logic [6:0] WIN_LONG = 7'h40;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PI_BURST = 2'b00,
    PI_SYMBOL = 2'b01,
    PI_START_BIT = 2'b10,
    PI_RESERVED = 2'b11
  } pattern_interp_e;

  typedef enum logic [1:0] {
    SC_212K = 2'b00,
    SC_424K = 2'b01,
    SC_848K = 2'b10
  } subcarrier_e;

  typedef enum logic [1:0] {
    DM_ASK = 2'b00,
    DM_FSK = 2'b01,
    DM_BPSK = 2'b10,
    DM_FSK_BPSK = 2'b11
  } demod_e;

  typedef struct packed {
    logic [3:0]      pattern_bit_count;
    logic            grid_on_falling_edge;
    logic            final_pattern_bit_short;
    pattern_interp_e pattern_interpretation;
    logic            four_sample_average_en;
    logic            squaring_shaper_en;
    logic            grid_at_peak_sel;
    logic            manchester_sense_invert;
    demod_e          demod_scheme;
    subcarrier_e     subcarrier;
    logic [15:0]     corr_clocks;
    logic [6:0]      corr_window;
    logic [7:0]      trim;
  } rx_cfg_s;

endpackage

// ==== src/sample_conditioner.sv ====
// Converter sample shaping and four-sample averaging.
// Assumes samples arrive on the same clock as a one-cycle valid.
`timescale 1ns/100ps
module sample_conditioner #(
  parameter int unsigned SW = 8
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  // Control
  input  wire logic          avg_en,
  input  wire logic          shape_en,
  // Sample stream
  input  wire logic          in_valid,
  input  wire logic [SW-1:0] in_data,
  output logic               out_valid,
  output logic [SW-1:0]      out_data
);

  localparam logic [SW:0] MID = (SW+1)'(1) << (SW-1);
  localparam logic [SW:0] TOP = ((SW+1)'(1) << SW) - (SW+1)'(1);

  logic [SW:0]   shaped;
  logic [SW+1:0] acc_r;
  logic [1:0]    cnt_r;

  // Doubles the distance from mid-scale and clips, squaring the wave
  always_comb
  begin
    shaped = {1'b0, in_data};
    if (shape_en)
    begin
      if ({1'b0, in_data} >= MID)
        shaped = ({1'b0, in_data} << 1) - MID;
      else if ({1'b0, in_data} < (MID >> 1))
        shaped = '0;
      else
        shaped = ({1'b0, in_data} << 1) - MID;
      if (shaped > TOP)
        shaped = TOP;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_r     <= '0;
      cnt_r     <= 2'h0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= 1'b0;
      if (in_valid && !avg_en)
      begin
        out_valid <= 1'b1;
        out_data  <= shaped[SW-1:0];
        cnt_r     <= 2'h0;
        acc_r     <= '0;
      end
      else if (in_valid)
      begin
        cnt_r <= cnt_r + 2'h1;
        if (cnt_r == 2'h3)
        begin
          out_valid <= 1'b1;
          out_data  <= (SW)'((acc_r + {1'b0, shaped}) >> 2);
          acc_r     <= '0;
        end
        else
          acc_r <= acc_r + {1'b0, shaped};
      end
    end
  end

endmodule // sample_conditioner

// ==== src/rx_sync_correlation_config.sv ====
// Configuration bank steering receiver sync, demodulation, correlation.
// Assumes a single-cycle strobe register port and same-clock streams.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
module rx_sync_correlation_config #(
  parameter int unsigned SW = 8,
  parameter int unsigned CW = 12,
  parameter logic [7:0]  TRIM_BOOT = 8'hA5, // Arbitrary value
  parameter logic [15:0] CLK_ISO = 16'h0010,
  parameter logic [15:0] CLK_MID = 16'h0020,
  parameter logic [15:0] CLK_SLOW = 16'h0040
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // Converter samples
  input  wire logic                 smp_valid,
  input  wire logic [SW-1:0]        smp_data,
  output logic                      cond_valid,
  output logic [SW-1:0]             cond_data,
  // Correlation result
  input  wire logic                 frame_start,
  input  wire logic                 corr_valid,
  input  wire logic signed [CW-1:0] corr_value,
  output logic                      grid_strobe,
  // Manchester halves
  input  wire logic                 half_valid,
  input  wire logic                 half_first,
  input  wire logic                 half_second,
  output logic                      man_valid,
  output logic                      man_bit,
  // Received bits for start of frame
  input  wire logic                 rxbit_valid,
  input  wire logic                 rxbit_data,
  input  wire logic                 rxbit_coll,
  input  wire logic                 start_bit_seen,
  output logic                      sof_match,
  output logic                      resync,
  // Configuration out
  output rx_cfg_pkg::rx_cfg_s       cfg,
  output logic [15:0]               sof_pattern_word
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] pat_hi_r;
  logic [7:0] pat_lo_r;
  logic [7:0] sof_mode_r;
  logic [7:0] demod_r;
  logic [7:0] corr_r;
  logic [7:0] trim_r;
  logic       boot_r;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    return a == ofs;
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat_hi_r   <= rx_cfg_pkg::RST_PAT;
      pat_lo_r   <= rx_cfg_pkg::RST_PAT;
      sof_mode_r <= rx_cfg_pkg::RST_SOF_MODE;
      demod_r    <= rx_cfg_pkg::RST_DEMOD;
      corr_r     <= rx_cfg_pkg::RST_CORR;
    end
    else if (reg_wr)
    begin
      if (hit(reg_addr, rx_cfg_pkg::OFS_PAT_HI))
        pat_hi_r <= reg_wdata;
      if (hit(reg_addr, rx_cfg_pkg::OFS_PAT_LO))
        pat_lo_r <= reg_wdata;
      if (hit(reg_addr, rx_cfg_pkg::OFS_SOF_MODE))
        sof_mode_r <= reg_wdata;
      if (hit(reg_addr, rx_cfg_pkg::OFS_DEMOD))
        demod_r <= reg_wdata & rx_cfg_pkg::MSK_DEMOD;
      if (hit(reg_addr, rx_cfg_pkg::OFS_CORR))
        corr_r <= reg_wdata & rx_cfg_pkg::MSK_CORR;
    end
  end

  // Trim takes its boot value on the first edge after reset release
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_r <= 1'b1;
      trim_r <= 8'h00;
    end
    else
    begin
      boot_r <= 1'b0;
      if (boot_r)
        trim_r <= TRIM_BOOT;
      else if (reg_wr && hit(reg_addr, rx_cfg_pkg::OFS_TRIM))
        trim_r <= reg_wdata;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        rx_cfg_pkg::OFS_PAT_HI:   reg_rdata <= pat_hi_r;
        rx_cfg_pkg::OFS_PAT_LO:   reg_rdata <= pat_lo_r;
        rx_cfg_pkg::OFS_SOF_MODE: reg_rdata <= sof_mode_r;
        rx_cfg_pkg::OFS_DEMOD:    reg_rdata <= demod_r;
        rx_cfg_pkg::OFS_CORR:     reg_rdata <= corr_r;
        rx_cfg_pkg::OFS_TRIM:     reg_rdata <= trim_r;
        default:                  reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [3:0]                    len;
  rx_cfg_pkg::pattern_interp_e   interp;

  assign len = sof_mode_r[rx_cfg_pkg::POS_LEN +: 4];
  assign interp = rx_cfg_pkg::pattern_interp_e'(
                    sof_mode_r[rx_cfg_pkg::POS_TYPE +: 2]);
  assign sof_pattern_word = {pat_hi_r, pat_lo_r};

  always_comb
  begin
    cfg = '0;
    cfg.pattern_bit_count = len;
    cfg.grid_on_falling_edge = sof_mode_r[rx_cfg_pkg::POS_NEG];
    cfg.final_pattern_bit_short = sof_mode_r[rx_cfg_pkg::POS_HALF];
    cfg.pattern_interpretation = interp;
    cfg.four_sample_average_en = demod_r[rx_cfg_pkg::POS_AVG];
    cfg.squaring_shaper_en = demod_r[rx_cfg_pkg::POS_SHAPE];
    cfg.grid_at_peak_sel = demod_r[rx_cfg_pkg::POS_PEAK];
    cfg.manchester_sense_invert = demod_r[rx_cfg_pkg::POS_INV];
    cfg.demod_scheme = rx_cfg_pkg::demod_e'(
      {demod_r[rx_cfg_pkg::POS_BPSK], demod_r[rx_cfg_pkg::POS_FSK]});
    case (corr_r[rx_cfg_pkg::POS_FREQ +: 2])
      2'h0:    cfg.subcarrier = rx_cfg_pkg::SC_212K;
      2'h1:    cfg.subcarrier = rx_cfg_pkg::SC_424K;
      default: cfg.subcarrier = rx_cfg_pkg::SC_848K;
    endcase
    case (corr_r[rx_cfg_pkg::POS_RATE +: 2])
      2'h0:    cfg.corr_clocks = CLK_ISO;
      2'h1:    cfg.corr_clocks = CLK_MID;
      2'h2:    cfg.corr_clocks = CLK_SLOW;
      default: cfg.corr_clocks = CLK_ISO;
    endcase
    cfg.corr_window = corr_r[rx_cfg_pkg::POS_SHORT]
                      ? rx_cfg_pkg::WIN_SHORT
                      : rx_cfg_pkg::WIN_LONG;
    cfg.trim = trim_r;
  end

  // ----------------------------------------------------------------
  // Sample conditioning
  // ----------------------------------------------------------------
  sample_conditioner #(
    .SW (SW)
  ) u_cond (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .avg_en    (cfg.four_sample_average_en),
    .shape_en  (cfg.squaring_shaper_en),
    .in_valid  (smp_valid),
    .in_data   (smp_data),
    .out_valid (cond_valid),
    .out_data  (cond_data)
  );

  // ----------------------------------------------------------------
  // Bit grid placement
  // ----------------------------------------------------------------
  logic signed [CW-1:0] prev_r;
  logic                 rising_r;
  logic                 falling_r;
  logic                 have_r;
  logic                 armed_r;
  logic                 drop;
  logic                 climb;

  assign drop = have_r && (corr_value < prev_r);
  assign climb = have_r && (corr_value > prev_r);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_r      <= '0;
      rising_r    <= 1'b0;
      falling_r   <= 1'b0;
      have_r      <= 1'b0;
      armed_r     <= 1'b0;
      grid_strobe <= 1'b0;
    end
    else
    begin
      grid_strobe <= 1'b0;
      if (frame_start)
      begin
        have_r  <= 1'b0;
        armed_r <= 1'b1;
      end
      else if (corr_valid)
      begin
        prev_r    <= corr_value;
        have_r    <= 1'b1;
        rising_r  <= climb;
        falling_r <= drop;
        if (cfg.grid_on_falling_edge)
        begin
          if (armed_r && drop)
          begin
            grid_strobe <= 1'b1;
            armed_r     <= 1'b0;
          end
        end
        else if (cfg.grid_at_peak_sel)
          grid_strobe <= rising_r && drop;
        else
          grid_strobe <= falling_r && climb;
      end
    end
  end

  // ----------------------------------------------------------------
  // Manchester decode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      man_valid <= 1'b0;
      man_bit   <= 1'b0;
    end
    else
    begin
      man_valid <= half_valid;
      if (half_valid)
        man_bit <= (half_first & ~half_second)
                   ^ cfg.manchester_sense_invert;
    end
  end

  // ----------------------------------------------------------------
  // Start of frame matching
  // ----------------------------------------------------------------
  logic [15:0] hist_d_r;
  logic [15:0] hist_c_r;
  logic [15:0] hist_d;
  logic [15:0] hist_c;
  logic [15:0] mask;
  logic        burst_ok;
  logic        sym_ok;

  assign hist_d = {hist_d_r[14:0], rxbit_data};
  assign hist_c = {hist_c_r[14:0], rxbit_coll};
  assign mask = 16'((17'h1 << len) - 17'h1);

  // Each pair {data, coll}: a set coll expects a collision only
  always_comb
  begin
    burst_ok = ((hist_d ^ sof_pattern_word) & mask) == 16'h0000;
    sym_ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (mask[2*i+1])
      begin
        if (sof_pattern_word[2*i])
          sym_ok = sym_ok & hist_c[i];
        else
          sym_ok = sym_ok & ~hist_c[i]
                   & (hist_d[i] == sof_pattern_word[2*i+1]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hist_d_r  <= 16'h0000;
      hist_c_r  <= 16'h0000;
      sof_match <= 1'b0;
      resync    <= 1'b0;
    end
    else
    begin
      sof_match <= 1'b0;
      resync    <= 1'b0;
      if (frame_start)
      begin
        hist_d_r <= 16'h0000;
        hist_c_r <= 16'h0000;
      end
      else if (rxbit_valid)
      begin
        hist_d_r <= hist_d;
        hist_c_r <= hist_c;
        case (interp)
          rx_cfg_pkg::PI_BURST:
            sof_match <= (len != 4'h0) && burst_ok;
          rx_cfg_pkg::PI_SYMBOL:
            sof_match <= (len > 4'h1) && sym_ok;
          default:
            sof_match <= 1'b0;
        endcase
      end
      if (interp == rx_cfg_pkg::PI_START_BIT && start_bit_seen)
        resync <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_READ_MODE: assert property (reg_rd && reg_addr ==
    rx_cfg_pkg::OFS_SOF_MODE && !$past(reg_wr) |=> reg_rdata == sof_mode_r)
    else $error("mode readback wrong");
  AST_RSV_DEMOD: assert property (demod_r[7:6] == 2'b00)
    else $error("reserved demod bits set");
  AST_RSV_CORR: assert property (corr_r[2:0] == 3'b000)
    else $error("reserved corr bits set");
  AST_NO_LEN_NO_MATCH: assert property (len == 4'h0 && $past(len) == 4'h0
    |-> !sof_match) else $error("match with zero length");
  AST_RESYNC: assert property (start_bit_seen
    && interp == rx_cfg_pkg::PI_START_BIT |=> resync)
    else $error("missing resync");
  AST_NO_RESYNC: assert property (resync |-> $past(interp)
    == rx_cfg_pkg::PI_START_BIT) else $error("stray resync");
  AST_MAN: assert property (half_valid && half_first && !half_second
    && !cfg.manchester_sense_invert |=> man_valid && man_bit)
    else $error("manchester sense wrong");
  AST_WIN: assert property (cfg.corr_window ==
    (corr_r[3] ? 7'h20 : 7'h40)) else $error("window wrong");
  AST_FREQ: assert property (corr_r[7] |->
    cfg.subcarrier == rx_cfg_pkg::SC_848K)
    else $error("freq decode wrong");
  AST_ONE_FALL: assert property (grid_strobe && cfg.grid_on_falling_edge
    && !frame_start |=> !grid_strobe) else $error("double grid");

  COV_MATCH: cover property (sof_match);
  COV_SYMBOL: cover property (sof_match
    && interp == rx_cfg_pkg::PI_SYMBOL);
  COV_GRID: cover property (grid_strobe);
  COV_AVG: cover property (cond_valid && cfg.four_sample_average_en);

endmodule // rx_sync_correlation_config

// ==== test/card_model.sv ====
// Behavioural transponder: received bit stream and start-bit marks.
// Assumes the bench calls its tasks and shares the receiver clock.
`timescale 1ns/100ps
module card_model (
  // Clock
  input  wire logic ref_clk,
  // Bit stream toward the receiver
  output logic      rxbit_valid,
  output logic      rxbit_data,
  output logic      rxbit_coll,
  output logic      start_bit_seen
);
  initial
  begin
    rxbit_valid = 1'b0;
    rxbit_data = 1'b0;
    rxbit_coll = 1'b0;
    start_bit_seen = 1'b0;
  end

  // Outside a pulse the lines flip, so a stale value can never match
  task automatic send_bit(input logic d, input logic c);
    @(posedge ref_clk);
    rxbit_valid <= 1'b1;
    rxbit_data  <= d;
    rxbit_coll  <= c;
    @(posedge ref_clk);
    rxbit_valid <= 1'b0;
    rxbit_data  <= ~d;
    rxbit_coll  <= ~c;
  endtask

  task automatic start_bit();
    @(posedge ref_clk);
    start_bit_seen <= 1'b1;
    @(posedge ref_clk);
    start_bit_seen <= 1'b0;
  endtask
endmodule // card_model

// ==== test/rx_sync_correlation_config_tb.sv ====
// Self-checking bench for the receiver configuration bank.
// Assumes the card model drives the received bit stream.
`timescale 1ns/100ps
`define CHK(n, e, g) \
  begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module rx_sync_correlation_config_tb;
  localparam logic [15:0] CLK_I = 16'h0010;
  localparam logic [15:0] CLK_M = 16'h0020;
  localparam logic [15:0] CLK_S = 16'h0040;
  localparam logic [7:0]  TRIM_V = 8'h5E; // Arbitrary value
  logic ref_clk, arst_n, reg_wr, reg_rd, smp_valid, cond_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, smp_data, cond_data;
  logic frame_start, corr_valid, grid_strobe, half_valid, half_first;
  logic half_second, man_valid, man_bit, rxbit_valid, rxbit_data;
  logic rxbit_coll, start_bit_seen, sof_match, resync;
  logic signed [11:0] corr_value;
  rx_cfg_pkg::rx_cfg_s cfg;
  logic [15:0] sof_pattern_word;
  logic [31:0] lf;
  logic [7:0] v, sm, dm, cr, hi, lo;
  int err_count, n_checks, i, k, e, g;
  int sq[$];
  int cv[5] = '{1, 3, 2, 5, 1};

  rx_sync_correlation_config #(.TRIM_BOOT(TRIM_V), .CLK_ISO(CLK_I),
    .CLK_MID(CLK_M), .CLK_SLOW(CLK_S)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_data(smp_data), .cond_valid(cond_valid),
    .cond_data(cond_data), .frame_start(frame_start),
    .corr_valid(corr_valid), .corr_value(corr_value),
    .grid_strobe(grid_strobe), .half_valid(half_valid),
    .half_first(half_first), .half_second(half_second),
    .man_valid(man_valid), .man_bit(man_bit), .rxbit_valid(rxbit_valid),
    .rxbit_data(rxbit_data), .rxbit_coll(rxbit_coll),
    .start_bit_seen(start_bit_seen), .sof_match(sof_match),
    .resync(resync), .cfg(cfg), .sof_pattern_word(sof_pattern_word));
  card_model card (.ref_clk(ref_clk), .rxbit_valid(rxbit_valid),
    .rxbit_data(rxbit_data), .rxbit_coll(rxbit_coll),
    .start_bit_seen(start_bit_seen));

  always #25 ref_clk = ~ref_clk;

  // ------------------------------------------------------------------
  // Drivers and model
  // ------------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04C11DB7 : 32'h0);
    return lf[7:0];
  endfunction

  function automatic int shp(input int s);
    int t;
    t = 2 * s - 128;
    if (s < 64)
      t = 0;
    else if (t > 255)
      t = 255;
    return t;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic smp(input logic [7:0] d);
    @(posedge ref_clk);
    smp_valid <= 1'b1;
    smp_data  <= d;
    @(posedge ref_clk);
    smp_valid <= 1'b0;
    smp_data  <= ~d;
    #1;
  endtask

  task automatic frame();
    @(posedge ref_clk);
    frame_start <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
  endtask

  task automatic chk_cfg();
    logic [15:0] ck;
    ck = (cr[5:4] == 2'd1) ? CLK_M : (cr[5:4] == 2'd2) ? CLK_S : CLK_I;
    `CHK("len", sm[7:4], cfg.pattern_bit_count)
    `CHK("neg", sm[3], cfg.grid_on_falling_edge)
    `CHK("half", sm[2], cfg.final_pattern_bit_short)
    `CHK("type", sm[1:0], cfg.pattern_interpretation)
    `CHK("avg", dm[5], cfg.four_sample_average_en)
    `CHK("shape", dm[4], cfg.squaring_shaper_en)
    `CHK("peak", dm[3], cfg.grid_at_peak_sel)
    `CHK("inv", dm[2], cfg.manchester_sense_invert)
    `CHK("demod", {dm[0], dm[1]}, cfg.demod_scheme)
    `CHK("freq", cr[7] ? 2'b10 : cr[7:6], cfg.subcarrier)
    `CHK("rate", ck, cfg.corr_clocks)
    `CHK("win", cr[3] ? 7'h20 : 7'h40, cfg.corr_window)
    `CHK("word", {hi, lo}, sof_pattern_word)
    `CHK("trim cfg", TRIM_V, cfg.trim)
  endtask

  task automatic grid(input logic [7:0] m, input logic [7:0] d, int x);
    wr(8'h5C, m);
    wr(8'h5D, d);
    frame();
    g = 0;
    for (int j = 0; j < 5; j++)
    begin
      @(posedge ref_clk);
      corr_valid <= 1'b1;
      corr_value <= 12'(cv[j]);
      @(posedge ref_clk);
      corr_valid <= 1'b0;
      #1 g += int'(grid_strobe === 1'b1);
    end
    `CHK("grid", x, g)
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    {ref_clk, arst_n, reg_wr, reg_rd, smp_valid, frame_start} = '0;
    {corr_valid, half_valid, half_first, half_second} = '0;
    {reg_addr, reg_wdata, smp_data, corr_value} = '0;
    lf = 32'h40256F4A;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (i = 'h5A; i < 'h5F; i++)
    begin
      rd(8'(i), v);
      `CHK("reset", 8'h00, v)
    end
    rd(8'h5F, v);
    `CHK("trim", TRIM_V, v)
    for (k = 0; k < 8; k++)
    begin
      {sm, dm, cr, hi, lo} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      wr(8'h5A, hi);
      wr(8'h5B, lo);
      wr(8'h5C, sm);
      wr(8'h5D, dm);
      wr(8'h5E, cr);
      wr(8'h60, rnd());
      rd(8'h5C, v);
      `CHK("mode", sm, v)
      rd(8'h5D, v);
      `CHK("demod", dm & 8'h3F, v)
      rd(8'h5E, v);
      `CHK("corr", cr & 8'hF8, v)
      rd(8'h60, v);
      `CHK("unmapped", 8'h00, v)
      chk_cfg();
    end
    for (k = 0; k < 8; k++)
    begin
      wr(8'h5D, {5'h0, k[2], 2'b0});
      @(posedge ref_clk);
      {half_valid, half_first, half_second} <= {1'b1, k[1], k[0]};
      @(posedge ref_clk);
      half_valid <= 1'b0;
      #1 `CHK("man", (k[1] & ~k[0]) ^ k[2], man_bit)
      `CHK("man valid", 1'b1, man_valid)
    end
    wr(8'h5D, 8'h10);
    for (k = 0; k < 6; k++)
    begin
      v = rnd();
      smp(v);
      `CHK("shaped", 8'(shp(v)), cond_data)
    end
    wr(8'h5D, 8'h20);
    for (k = 0; k < 8; k++)
    begin
      v = rnd();
      sq.push_back(int'(v));
      smp(v);
      `CHK("avg valid", sq.size() == 4, cond_valid)
      if (sq.size() == 4)
      begin
        `CHK("avg", 8'(sq.sum() / 4), cond_data)
        sq.delete();
      end
    end
    grid(8'h00, 8'h08, 2);
    grid(8'h00, 8'h00, 1);
    grid(8'h08, 8'h08, 1);
    wr(8'h5A, 8'h3C);
    wr(8'h5B, 8'hA5);
    wr(8'h5C, 8'hC0);
    for (e = 0; e < 2; e++)
    begin
      frame();
      g = 0;
      for (i = 11; i >= 0; i--)
      begin
        card.send_bit(1'(16'h3CA5 >> i) ^ (i == 0 && e == 1), 1'b0);
        #1 g += int'(sof_match === 1'b1);
      end
      `CHK("burst sof", 1 - e, g)
    end
    wr(8'h5B, 8'h0B);
    wr(8'h5C, 8'h41);
    for (e = 0; e < 3; e++)
    begin
      frame();
      card.send_bit(1'b1, 1'b0);
      card.send_bit(e == 2, e != 1);
      #1 `CHK("symbol sof", e != 1, sof_match)
    end
    wr(8'h5C, 8'h02);
    card.start_bit();
    #1 `CHK("resync", 1'b1, resync)
    wr(8'h5C, 8'h00);
    card.start_bit();
    #1 `CHK("no resync", 1'b0, resync)
    end_sim();
  end
endmodule // rx_sync_correlation_config_tb
